// File: common/mws_params.svh
`ifndef MWS_PARAMS_SVH
`define MWS_PARAMS_SVH
`define MWS_SAMPLE_W      20
`define MWS_GAIN_W        12
`define MWS_WORD_W        40
`define MWS_BYTE_W        8
`define MWS_POS_LIMIT     20'h40000
`define MWS_NEG_LIMIT     20'hC0000
`define MWS_GAIN_SHIFT    12
`define MWS_BASE_DIV      128
`define MWS_DIV_CNT_W     11
`define MWS_LPF_SHIFT     5
`define MWS_FIFO_DEPTH    16
`define MWS_FIFO_AW       4
`define MWS_SRC_POWER     2'h0
`define MWS_SRC_BOTH      2'h1
`define MWS_SRC_CH1       2'h2
`define MWS_SRC_CH2       2'h3
`define MWS_PGA_W         3
`define MWS_PGA_MAX       3'h4
`endif

// File: common/mws_pkg.sv
package mws_pkg;
  typedef enum logic [1:0] {
    MWS_SRC_POWER_E = 2'h0,
    MWS_SRC_BOTH_E  = 2'h1,
    MWS_SRC_CH1_E   = 2'h2,
    MWS_SRC_CH2_E   = 2'h3
  } mws_src_t;
  typedef enum logic [1:0] {
    MWS_TX_IDLE = 2'h0,
    MWS_TX_LOAD = 2'h1,
    MWS_TX_SEND = 2'h3
  } mws_tx_state_t;
endpackage : mws_pkg

// File: rtl/mws_fifo.sv
`timescale 1ns/1ps
module mws_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and control
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_ce,
  // write side
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // read side
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             do_wr, do_rd;

  always_comb begin
    do_wr    = i_wr_valid && (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
    do_rd    = i_rd_ready && (cnt_reg != '0);
    wp_next  = do_wr ? wp_reg + 1'b1 : wp_reg;
    rp_next  = do_rd ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt_reg != '0);
  assign o_rd_data  = mem_reg[rp_reg];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else if (i_ce) begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      if (do_wr) begin
        mem_reg[wp_reg] <= i_wr_data;
      end
    end
  end
endmodule : mws_fifo

// File: rtl/mws_sampler.sv
`timescale 1ns/1ps
`include "mws_params.svh"
module mws_sampler (
  // clock and control
  input  wire logic                       I_CLK,
  input  wire logic                       I_SRST,
  input  wire logic                       I_CE,
  // converter results, same clock
  input  wire logic                       I_CH1_VALID,
  input  wire logic [`MWS_SAMPLE_W-1:0]   I_CH1_CODE,
  input  wire logic                       I_CH1_OVR_POS,
  input  wire logic                       I_CH1_OVR_NEG,
  input  wire logic [`MWS_SAMPLE_W-1:0]   I_CH2_CODE,
  // configuration
  input  wire logic [`MWS_GAIN_W-1:0]     I_POWER_GAIN_WORD,
  input  wire mws_pkg::mws_src_t          I_WAVE_SRC,
  input  wire logic [1:0]                 I_SAMPLE_RATE_SELECT,
  input  wire logic                       I_SAMPLE_READY_ENABLE,
  input  wire logic [`MWS_PGA_W-1:0]      I_CH2_PGA,
  // power path
  output logic [`MWS_WORD_W-1:0]          O_INST_POWER,
  output logic [`MWS_WORD_W-1:0]          O_ACTIVE_POWER,
  output logic [`MWS_WORD_W-1:0]          O_ENERGY,
  // waveform register and byte stream
  output logic [`MWS_WORD_W-1:0]          O_WAVEFORM,
  output logic                            O_IRQ_N,
  input  wire logic                       I_IRQ_ACK,
  output logic                            O_BYTE_VALID,
  input  wire logic                       I_BYTE_READY,
  output logic [`MWS_BYTE_W-1:0]          O_BYTE,
  output logic                            O_BYTE_LAST
);
  import mws_pkg::*;

  function automatic logic [23:0] sext24(input logic [`MWS_SAMPLE_W-1:0] v);
    sext24 = {{(24-`MWS_SAMPLE_W){v[`MWS_SAMPLE_W-1]}}, v};
  endfunction : sext24

  function automatic logic signed [`MWS_SAMPLE_W-1:0] clamp20(input logic signed [39:0] v);
    if (v > 40'sh0000040000) begin
      clamp20 = `MWS_POS_LIMIT;
    end else if (v < -40'sh0000040000) begin
      clamp20 = `MWS_NEG_LIMIT;
    end else begin
      clamp20 = v[`MWS_SAMPLE_W-1:0];
    end
  endfunction : clamp20

  logic signed [`MWS_SAMPLE_W-1:0] ch1_reg, ch1_next, ch2_reg, ch2_next;
  logic signed [`MWS_SAMPLE_W-1:0] lpf_reg, lpf_next;
  logic [`MWS_WORD_W-1:0]          wave_reg, wave_next, inst_reg, inst_next;
  logic [`MWS_WORD_W-1:0]          ap_reg, ap_next, en_reg, en_next;
  logic [`MWS_DIV_CNT_W-1:0]       div_reg, div_next;
  logic                            irq_reg, irq_next, push;
  logic [2:0]                      nbytes;
  logic signed [39:0]              ch1_raw, ch1_scaled, ch2_raw;
  logic [`MWS_DIV_CNT_W-1:0]       div_top;
  logic                            f_valid, f_ready, t_ready;
  logic [`MWS_WORD_W-1:0]          f_data, push_word;

  always_comb begin
    // over-range flags force the limit ahead of the gain stage, never a wrapped code
    ch1_raw = 40'(signed'(I_CH1_CODE));
    if (I_CH1_OVR_POS) begin
      ch1_raw = 40'sh0000040000;
    end else if (I_CH1_OVR_NEG) begin
      ch1_raw = -40'sh0000040000;
    end
    // code * (1 + g/4096)
    ch1_scaled = ch1_raw + ((ch1_raw * 40'(signed'(I_POWER_GAIN_WORD))) >>> `MWS_GAIN_SHIFT);
    ch1_next = I_CH1_VALID ? clamp20(ch1_scaled) : ch1_reg;
    // pga gain as shift, same code scale as channel 1
    ch2_raw  = 40'(signed'(I_CH2_CODE)) <<< ((I_CH2_PGA > `MWS_PGA_MAX) ? `MWS_PGA_MAX : I_CH2_PGA);
    ch2_next = I_CH1_VALID ? clamp20(ch2_raw) : ch2_reg;
    // one-pole smoothing, shift sets corner near 156 Hz at top rate
    lpf_next = I_CH1_VALID ? lpf_reg + ((ch2_reg - lpf_reg) >>> `MWS_LPF_SHIFT) : lpf_reg;
    // unfiltered channel 2 feeds the multiplier
    inst_next = I_CH1_VALID ? 40'(ch1_reg * ch2_reg) : inst_reg;
    // energy keeps running in every waveform mode
    ap_next = I_CH1_VALID ? ap_reg + 40'(signed'(inst_reg - ap_reg) >>> `MWS_LPF_SHIFT) : ap_reg;
    en_next = I_CH1_VALID ? en_reg + ap_reg : en_reg;
    // divide by 1, 2, 4, 8 of the top rate
    div_top = `MWS_DIV_CNT_W'(`MWS_BASE_DIV) << I_SAMPLE_RATE_SELECT;
    div_next = (div_reg >= div_top - 1'b1) ? '0 : div_reg + 1'b1;
    push = (div_reg == '0) && I_SAMPLE_READY_ENABLE;
    case (I_WAVE_SRC)
      MWS_SRC_CH1_E: begin
        push_word = {16'h0000, sext24(ch1_reg)};
        nbytes    = 3'h3;
      end
      MWS_SRC_BOTH_E: begin
        push_word = {ch1_reg, ch2_reg};
        nbytes    = 3'h5;
      end
      MWS_SRC_CH2_E: begin
        push_word = {16'h0000, sext24(lpf_reg)};
        nbytes    = 3'h3;
      end
      default: begin
        push_word = {16'h0000, ap_reg[23:0]};
        nbytes    = 3'h3;
      end
    endcase
    wave_next = (push && f_ready) ? push_word : wave_reg;
    // request held low until host acknowledges; new sample wins
    irq_next = (push && f_ready) ? 1'b1 : (I_IRQ_ACK ? 1'b0 : irq_reg);
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ch1_reg  <= '0;
      ch2_reg  <= '0;
      lpf_reg  <= '0;
      inst_reg <= '0;
      ap_reg   <= '0;
      en_reg   <= '0;
      div_reg  <= '0;
      wave_reg <= '0;
      irq_reg  <= 1'b0;
    end else if (I_CE) begin
      ch1_reg  <= ch1_next;
      ch2_reg  <= ch2_next;
      lpf_reg  <= lpf_next;
      inst_reg <= inst_next;
      ap_reg   <= ap_next;
      en_reg   <= en_next;
      div_reg  <= div_next;
      wave_reg <= wave_next;
      irq_reg  <= irq_next;
    end
  end

  assign O_INST_POWER   = inst_reg;
  assign O_ACTIVE_POWER = ap_reg;
  assign O_ENERGY       = en_reg;
  assign O_WAVEFORM     = wave_reg;
  assign O_IRQ_N        = ~irq_reg;

  // byte count rides in the top bits so a mode change mid-stream is safe
  logic [`MWS_WORD_W+2:0] fifo_in, fifo_out;
  assign fifo_in = {nbytes, push_word};

  mws_fifo #(.WIDTH(`MWS_WORD_W+3), .DEPTH(`MWS_FIFO_DEPTH), .AW(`MWS_FIFO_AW)) u_fifo (
    .i_clk      (I_CLK),
    .i_srst     (I_SRST),
    .i_ce       (I_CE),
    .i_wr_valid (push),
    .o_wr_ready (f_ready),
    .i_wr_data  (fifo_in),
    .o_rd_valid (f_valid),
    .i_rd_ready (t_ready),
    .o_rd_data  (fifo_out)
  );
  assign f_data = fifo_out[`MWS_WORD_W-1:0];

  mws_tx u_tx (
    .i_clk    (I_CLK),
    .i_srst   (I_SRST),
    .i_ce     (I_CE),
    .i_valid  (f_valid),
    .o_ready  (t_ready),
    .i_word   (f_data),
    .i_nbytes (fifo_out[`MWS_WORD_W+2:`MWS_WORD_W]),
    .o_valid  (O_BYTE_VALID),
    .i_ready  (I_BYTE_READY),
    .o_byte   (O_BYTE),
    .o_last   (O_BYTE_LAST)
  );

  property p_clamp;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && I_CH1_VALID && I_CH1_OVR_POS && !I_POWER_GAIN_WORD[11]) |=> (ch1_reg == `MWS_POS_LIMIT);
  endproperty
  a_clamp: assert property (p_clamp) else $error("ch1 not clamped");

  property p_irq;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready) |=> !O_IRQ_N;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_no_push_off;
    @(posedge I_CLK) disable iff (I_SRST)
      !I_SAMPLE_READY_ENABLE |-> !push;
  endproperty
  a_no_push_off: assert property (p_no_push_off) else $error("push without enable");

  property p_both;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready && I_WAVE_SRC == MWS_SRC_BOTH_E)
        |=> (O_WAVEFORM == {$past(ch1_reg), $past(ch2_reg)});
  endproperty
  a_both: assert property (p_both) else $error("combined word wrong");

  property p_irq_clear;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && I_IRQ_ACK && !(push && f_ready)) |=> O_IRQ_N;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");

  property p_irq_hold;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && !O_IRQ_N && !I_IRQ_ACK) |=> !O_IRQ_N;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");

  property p_byte_hold;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && O_BYTE_VALID && !I_BYTE_READY) |=> (O_BYTE_VALID && $stable(O_BYTE));
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte not held");

  property p_last_valid;
    @(posedge I_CLK) disable iff (I_SRST)
      O_BYTE_LAST |-> O_BYTE_VALID;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last without valid");

  property p_clamp_neg;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && I_CH1_VALID && I_CH1_OVR_NEG && !I_CH1_OVR_POS && !I_POWER_GAIN_WORD[11])
        |=> (ch1_reg == `MWS_NEG_LIMIT);
  endproperty
  a_clamp_neg: assert property (p_clamp_neg) else $error("ch1 not clamped low");

  property p_ch1_val;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready && I_WAVE_SRC == MWS_SRC_CH1_E)
        |=> (O_WAVEFORM[19:0] == $past(ch1_reg));
  endproperty
  a_ch1_val: assert property (p_ch1_val) else $error("ch1 sample wrong");

  property p_ch1_sext;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready && I_WAVE_SRC == MWS_SRC_CH1_E)
        |=> (O_WAVEFORM[39:24] == 16'h0000 && O_WAVEFORM[23:20] == {4{O_WAVEFORM[19]}});
  endproperty
  a_ch1_sext: assert property (p_ch1_sext) else $error("sign extension wrong");

  property p_ch2_word;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready && I_WAVE_SRC == MWS_SRC_CH2_E)
        |=> (O_WAVEFORM[19:0] == $past(lpf_reg));
  endproperty
  a_ch2_word: assert property (p_ch2_word) else $error("smoothed sample wrong");

  property p_power_word;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && push && f_ready && I_WAVE_SRC == MWS_SRC_POWER_E)
        |=> (O_WAVEFORM[23:0] == $past(ap_reg[23:0]));
  endproperty
  a_power_word: assert property (p_power_word) else $error("power sample wrong");

  property p_full_drop;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && !f_ready && !I_IRQ_ACK) |=> ($stable(O_WAVEFORM) && $stable(O_IRQ_N));
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("update while full");

  property p_div_step;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && div_reg == '0) |=> (div_reg == `MWS_DIV_CNT_W'(1));
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider stuck");

  property p_lpf_hold;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && !I_CH1_VALID) |=> $stable(lpf_reg);
  endproperty
  a_lpf_hold: assert property (p_lpf_hold) else $error("filter moved");

  property p_inst;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && I_CH1_VALID) |=> (O_INST_POWER == 40'($past(ch1_reg) * $past(ch2_reg)));
  endproperty
  a_inst: assert property (p_inst) else $error("product not unfiltered");

  property p_energy;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && I_CH1_VALID) |=> (O_ENERGY == $past(O_ENERGY) + $past(O_ACTIVE_POWER));
  endproperty
  a_energy: assert property (p_energy) else $error("energy not accumulated");

  property p_ap_hold;
    @(posedge I_CLK) disable iff (I_SRST)
      (I_CE && !I_CH1_VALID) |=> $stable(O_ACTIVE_POWER);
  endproperty
  a_ap_hold: assert property (p_ap_hold) else $error("power moved");
endmodule : mws_sampler

// File: rtl/mws_tx.sv
`timescale 1ns/1ps
`include "mws_params.svh"
module mws_tx (
  // clock and control
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  // word in
  input  wire logic                    i_valid,
  output logic                         o_ready,
  input  wire logic [`MWS_WORD_W-1:0]  i_word,
  input  wire logic [2:0]              i_nbytes,
  // byte out
  output logic                         o_valid,
  input  wire logic                    i_ready,
  output logic [`MWS_BYTE_W-1:0]       o_byte,
  output logic                         o_last
);
  import mws_pkg::*;
  mws_tx_state_t            st_reg, st_next;
  logic [`MWS_WORD_W-1:0]   sh_reg, sh_next;
  logic [2:0]               left_reg, left_next;

  always_comb begin
    st_next   = st_reg;
    sh_next   = sh_reg;
    left_next = left_reg;
    o_ready   = 1'b0;
    case (st_reg)
      MWS_TX_IDLE: begin
        o_ready = 1'b1;
        if (i_valid) begin
          // left-align so the top byte always leaves first
          sh_next   = i_word << (`MWS_BYTE_W * (5 - 32'(i_nbytes)));
          left_next = i_nbytes;
          st_next   = MWS_TX_SEND;
        end
      end
      MWS_TX_SEND: begin
        if (i_ready) begin
          sh_next   = sh_reg << `MWS_BYTE_W;
          left_next = left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            st_next = MWS_TX_IDLE;
          end
        end
      end
      default: st_next = MWS_TX_IDLE;
    endcase
  end

  assign o_valid = (st_reg == MWS_TX_SEND);
  assign o_byte  = sh_reg[`MWS_WORD_W-1 -: `MWS_BYTE_W];
  assign o_last  = (left_reg == 3'h1);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg   <= MWS_TX_IDLE;
      sh_reg   <= '0;
      left_reg <= '0;
    end else if (i_ce) begin
      st_reg   <= st_next;
      sh_reg   <= sh_next;
      left_reg <= left_next;
    end
  end
endmodule : mws_tx

// File: testbench/mws_host.sv
`timescale 1ns/1ps
module mws_host (
  // clock and stall control
  input  wire logic        i_clk,
  input  wire logic        i_stall,
  // byte stream and request
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_byte_last,
  input  wire logic        i_irq_n,
  output logic             o_byte_ready,
  output logic             o_irq_ack,
  // assembled word
  output logic [39:0]      o_word,
  output logic [2:0]       o_nbytes,
  output logic             o_done
);
  logic [39:0] acc_reg;
  logic [2:0]  cnt_reg;
  initial begin
    acc_reg = '0;
    cnt_reg = '0;
    o_word = '0;
    o_nbytes = '0;
    o_done = 1'b0;
    o_irq_ack = 1'b0;
  end
  assign o_byte_ready = !i_stall;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    // one ack pulse per request, so a fresh push can pull it low again
    o_irq_ack <= !i_irq_n && !o_irq_ack;
    if (i_byte_valid && o_byte_ready) begin
      if (i_byte_last) begin
        o_word <= {acc_reg[31:0], i_byte};
        o_nbytes <= cnt_reg + 3'h1;
        o_done <= 1'b1;
        acc_reg <= '0;
        cnt_reg <= '0;
      end else begin
        acc_reg <= {acc_reg[31:0], i_byte};
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end
endmodule : mws_host

// File: testbench/test_metering_waveform_sampler.sv
`timescale 1ns/1ps
module test_metering_waveform_sampler;
  import mws_pkg::*;
  logic        clk, srst, ch1_valid, ovr_pos, ovr_neg, enable, stall;
  logic        irq_n, irq_ack, bvalid, bready, blast, done;
  logic [19:0] code1, code2;
  logic [11:0] gain;
  logic [1:0]  rate;
  logic [2:0]  pga, nb;
  logic [7:0]  bdata;
  logic [39:0] word, inst, act, energy, wave, w, e0;
  mws_src_t    src;
  int          num_errors, n_tests, n;
  longint      t0;
  logic        irq_seen;
  mws_sampler dut (.I_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .I_CH1_VALID(ch1_valid),
    .I_CH1_CODE(code1), .I_CH1_OVR_POS(ovr_pos), .I_CH1_OVR_NEG(ovr_neg),
    .I_CH2_CODE(code2), .I_POWER_GAIN_WORD(gain), .I_WAVE_SRC(src),
    .I_SAMPLE_RATE_SELECT(rate), .I_SAMPLE_READY_ENABLE(enable), .I_CH2_PGA(pga),
    .O_INST_POWER(inst), .O_ACTIVE_POWER(act), .O_ENERGY(energy), .O_WAVEFORM(wave),
    .O_IRQ_N(irq_n), .I_IRQ_ACK(irq_ack), .O_BYTE_VALID(bvalid), .I_BYTE_READY(bready),
    .O_BYTE(bdata), .O_BYTE_LAST(blast));
  mws_host host (.i_clk(clk), .i_stall(stall), .i_byte_valid(bvalid), .i_byte(bdata),
    .i_byte_last(blast), .i_irq_n(irq_n), .o_byte_ready(bready), .o_irq_ack(irq_ack),
    .o_word(word), .o_nbytes(nb), .o_done(done));
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic get_word();
    int k;
    irq_seen = 1'b0;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (irq_n === 1'b0) irq_seen = 1'b1;
      if (done === 1'b1) break;
    end
    check("word arrival", 40'(k < 3000), 40'h1);
    w = word;
  endtask : get_word
  // three words flush whatever was in flight before the new codes
  task automatic send(input mws_src_t s, input logic [19:0] c1, input logic [19:0] c2,
                      input logic [2:0] nbx);
    @(negedge clk);
    src = s;
    code1 = c1;
    code2 = c2;
    ch1_valid = 1'b1;
    @(negedge clk);
    ch1_valid = 1'b0;
    repeat (3) get_word();
    check("byte count", 40'(nb), 40'(nbx));
    check("irq low", 40'(irq_seen), 40'h1);
  endtask : send
  task automatic run(input mws_src_t s, input logic [19:0] c1, input logic [19:0] c2,
                     input logic [2:0] nbx, input logic [39:0] exp);
    send(s, c1, c2, nbx);
    check("sample", w, exp);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1600000;
    num_errors++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    ch1_valid = 1'b0;
    ovr_pos = 1'b0;
    ovr_neg = 1'b0;
    enable = 1'b1;
    stall = 1'b0;
    code1 = 20'h0;
    code2 = 20'h0;
    gain = 12'h000;
    rate = 2'h0;
    pga = 3'h0;
    src = MWS_SRC_CH1_E;
    num_errors = 0;
    n_tests = 0;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    run(MWS_SRC_CH1_E, 20'h12345, 20'h0, 3'h3, 40'h012345);
    run(MWS_SRC_CH1_E, 20'hF0001, 20'h0, 3'h3, 40'hFF0001);
    ovr_pos = 1'b1;
    run(MWS_SRC_CH1_E, 20'h7FFFF, 20'h0, 3'h3, 40'h040000);
    ovr_pos = 1'b0;
    ovr_neg = 1'b1;
    run(MWS_SRC_CH1_E, 20'h80000, 20'h0, 3'h3, 40'hFC0000);
    ovr_neg = 1'b0;
    gain = 12'h7FF;
    run(MWS_SRC_CH1_E, 20'h01000, 20'h0, 3'h3, 40'h0017FF);
    gain = 12'h800;
    run(MWS_SRC_CH1_E, 20'h01000, 20'h0, 3'h3, 40'h000800);
    gain = 12'h000;
    for (int p = 0; p < 5; p++) begin
      pga = 3'(p);
      run(MWS_SRC_BOTH_E, 20'h00100, 20'h00100, 3'h5, {20'h00100, 20'(20'h00100 << p)});
    end
    pga = 3'h0;
    send(MWS_SRC_CH2_E, 20'h01000, 20'h08000, 3'h3);
    check("smoothed", 40'(w[23:0] < 24'h008000 && w[23:0] != 24'h0), 40'h1);
    @(negedge clk);
    src = MWS_SRC_CH1_E;
    ch1_valid = 1'b1;
    @(negedge clk);
    ch1_valid = 1'b0;
    check("inst power", inst, 40'h0008000000);
    e0 = energy;
    repeat (300) @(negedge clk);
    ch1_valid = 1'b1;
    @(negedge clk);
    ch1_valid = 1'b0;
    check("energy runs", 40'(energy !== e0), 40'h1);
    send(MWS_SRC_POWER_E, 20'h01000, 20'h08000, 3'h3);
    src = MWS_SRC_CH1_E;
    for (int r = 0; r < 4; r++) begin
      rate = 2'(r);
      repeat (2) get_word();
      t0 = $time;
      get_word();
      check("period", 40'(($time - t0) / 20), 40'(128 << r));
    end
    enable = 1'b0;
    repeat (300) @(negedge clk);
    n = 0;
    repeat (1200) begin
      @(negedge clk);
      if (done === 1'b1) n++;
    end
    check("no samples", 40'(n), 40'h0);
    check("irq idle", 40'(irq_n), 40'h1);
    stall = 1'b1;
    enable = 1'b1;
    repeat (20600) @(negedge clk);
    stall = 1'b0;
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (done === 1'b1) n++;
    end
    // the sender may hold one word beside the sixteen queued
    check("fifo depth", 40'(n == 16 || n == 17), 40'h1);
    close_out();
  end
endmodule : test_metering_waveform_sampler
